/* File: bench/slc_target_model.sv */
`timescale 1ns/1ps
`default_nettype none
module slc_target_model (
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic [4:0] n_i,
  input wire logic [23:0] data_i,
  output logic miso_o,
  output logic [23:0] mosi_word_o
);
  int idx;
  initial miso_o = 1'b0;
  initial mosi_word_o = '0;
  // Sampling edges meet a data-out change only at the phase 1 end-of-word flip; the two blocks share no variable, so no race here
  always @(sclk_i) begin
    if (!ss_n_i && ((sclk_i != cpol_i) != cpha_i)) begin
      mosi_word_o = {mosi_word_o[22:0], mosi_i};
    end
  end
  // Released line flips so a stale bit never passes for data
  always @(posedge ss_n_i) miso_o = ~miso_o;
  always @(negedge ss_n_i) begin
    idx = int'(n_i) - 1;
    mosi_word_o = '0;
    if (!cpha_i) miso_o = data_i[idx];
  end
  always @(sclk_i) begin
    if (!ss_n_i && sclk_i != cpol_i) begin
      if (cpha_i) miso_o = data_i[idx];
    end else if (!ss_n_i) begin
      idx--;
      if (idx < 0) miso_o = ~miso_o;
      else if (!cpha_i) miso_o = data_i[idx];
    end
  end
endmodule // slc_target_model
`default_nettype wire

/* File: bench/slc_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module slc_top_asserts
  import slc_pkg::*;
#(
  parameter int unsigned HALF_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sclk_o,
  input wire logic sclk_oe_o,
  input wire logic mosi_o,
  input wire logic mosi_oe_o,
  input wire logic ss_n_o,
  input wire logic ss_n_oe_o
);
  logic loop_q;
  wire logic acc = psel_i && penable_i && pready_o && pwrite_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) loop_q <= 1'b0;
    else if (acc && paddr_i == OFS_DIAG) loop_q <= pwdata_i[DIAG_LOOP_BIT];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_wait; psel_i && $rose(penable_i) |=> pready_o; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rd0; !pready_o |-> prdata_o == 32'h0000_0000; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside access");
  // Enable register, then one more flop in front of the pins
  property p_oe;
    acc && paddr_i == OFS_PIN_CFG |-> ##2
      (sclk_oe_o == $past(pwdata_i[PIN_EN_BIT], 2)
      && mosi_oe_o == $past(pwdata_i[PIN_EN_BIT], 2)
      && ss_n_oe_o == $past(pwdata_i[PIN_EN_BIT], 2));
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable not followed");
  property p_ss;
    acc && paddr_i == OFS_EXECUTE && !loop_q |-> ##2
      ss_n_o == $past(pwdata_i[EXE_SS_BIT], 2);
  endproperty
  a_ss: assert property (p_ss) else $error("select not following execute");
  property p_frz;
    loop_q && $past(loop_q, 2) |-> $stable(sclk_o) && $stable(mosi_o) && $stable(ss_n_o);
  endproperty
  a_frz: assert property (p_frz) else $error("pin moved in loopback");
  // Lower bound for the default half period of four cycles
  property p_sclk; $changed(sclk_o) && !loop_q |=> $stable(sclk_o) [*3]; endproperty
  a_sclk: assert property (p_sclk) else $error("serial clock half too short");
  c_go: cover property (acc && paddr_i == OFS_EXECUTE && pwdata_i[EXE_GO_BIT]);
  c_lb: cover property (loop_q && acc && paddr_i == OFS_EXECUTE);
  c_err: cover property (pslverr_o);
endmodule // slc_top_asserts
bind slc_top slc_top_asserts #(.HALF_CYC(HALF_CYC)) i_slc_top_asserts (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .sclk_o(sclk_o),
  .sclk_oe_o(sclk_oe_o),
  .mosi_o(mosi_o),
  .mosi_oe_o(mosi_oe_o),
  .ss_n_o(ss_n_o),
  .ss_n_oe_o(ss_n_oe_o)
);
`default_nettype wire

/* File: bench/spi_controller_read_loopback_test.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_controller_read_loopback_test;
  import slc_pkg::*;
  logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic pready_o, pslverr_o, sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, ss_n_o, ss_n_oe_o;
  logic miso_i, cpol = 0, cpha = 0;
  logic [4:0] nb = 5'h01;
  logic [23:0] td = '0;
  logic [23:0] mw;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  slc_top i_slc_top (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe_o),
    .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o),
    .ss_n_o(ss_n_o),
    .ss_n_oe_o(ss_n_oe_o),
    .miso_i(miso_i)
  );
  slc_target_model i_slc_target_model (
    .sclk_i(sclk_o),
    .ss_n_i(ss_n_o),
    .mosi_i(mosi_o),
    .cpol_i(cpol),
    .cpha_i(cpha),
    .n_i(nb),
    .data_i(td),
    .miso_o(miso_i),
    .mosi_word_o(mw)
  );
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(0, a, 32'h0, r, e);
  endtask
  task automatic pins_settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  initial begin
    logic [31:0] r;
    logic [23:0] tx, ex;
    logic e, lb;
    int k;
    void'($urandom(32'h38aa_ac11));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd(OFS_CONFIG, r);
    chk("config", 32'h0000_0018, r);
    rd(OFS_EXECUTE, r);
    chk("execute", 32'h0000_0002, r);
    apb(0, 12'h3FC, 32'h0, r, e);
    chk("unmapped", 32'h0000_0001, {31'h0, e});
    wr(OFS_PIN_CFG, 32'h0000_0001);
    pins_settle();
    chk("pin enable", 32'h0000_0007, {29'h0, sclk_oe_o, mosi_oe_o, ss_n_oe_o});
    for (int i = 0; i < 8; i++) begin
      lb = i[2];
      {cpol, cpha} = i[1:0];
      nb = i == 0 ? 5'h01 : i == 1 ? 5'h18 : 5'($urandom_range(24, 1));
      tx = 24'($urandom);
      td = 24'($urandom);
      wr(OFS_CONFIG, {25'h0, cpol, cpha, nb});
      wr(OFS_DIAG, {31'h0, lb});
      for (int b = 0; b < 3; b++) wr(OFS_TX_LOW + 12'(4 * b), {24'h0, tx[8 * b +: 8]});
      wr(OFS_EXECUTE, 32'h0000_0001);
      pins_settle();
      chk("select go", {31'h0, lb}, {31'h0, ss_n_o});
      k = 0;
      do begin
        rd(OFS_STATUS, r);
        k++;
      end while (r[STAT_DONE_BIT] !== 1'b1 && k < 200);
      chk("status", 32'h0000_0002, r);
      // Reference: loopback returns transmit bytes, else the target word
      ex = (lb ? tx : td) & ((24'h1 << nb) - 24'h1);
      for (int b = 0; b < 3; b++) begin
        rd(OFS_RX_LOW + 12'(4 * b), r);
        chk("rx byte", {24'h0, ex[8 * b +: 8]}, r);
      end
      if (!lb) chk("mosi word", {8'h0, tx & ((24'h1 << nb) - 24'h1)}, {8'h0, mw});
      wr(OFS_EXECUTE, 32'h0000_0002);
      pins_settle();
      chk("select end", 32'h0000_0001, {31'h0, ss_n_o});
      chk("clock idle", {31'h0, cpol}, {31'h0, sclk_o});
      wr(OFS_DIAG, 32'h0000_0000);
    end
    give_verdict();
  end
endmodule // spi_controller_read_loopback_test
`default_nettype wire

/* File: hw/slc_pkg.sv */
`default_nettype none
package slc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_EXECUTE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_TX_LOW = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_TX_MID = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_TX_HIGH = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_RX_LOW = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_RX_MID = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_RX_HIGH = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_DIAG = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_PIN_CFG = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h028;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG_CNT_LSB = 0;
  localparam int unsigned CFG_CPHA_BIT = 5;
  localparam int unsigned CFG_CPOL_BIT = 6;
  localparam int unsigned EXE_GO_BIT = 0;
  localparam int unsigned EXE_SS_BIT = 1;
  localparam int unsigned DIAG_LOOP_BIT = 0;
  localparam int unsigned PIN_EN_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [4:0] CNT_MAX = 5'h18;
  localparam logic [4:0] CNT_MIN = 5'h01;
  localparam logic [6:0] CONFIG_RST = 7'h18;
  localparam logic SS_RST = 1'b1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned SCLK_HALF_NS = 100;
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [0:0] {
    SLC_IDLE = 1'b0,
    SLC_SHIFT = 1'b1
  } slc_state_type;
endpackage
`default_nettype wire

/* File: hw/slc_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module slc_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule // slc_sync2
`default_nettype wire

/* File: hw/slc_top.sv */
// Functional notes
// - Execute 0x01 lowers select, starts transfer
// - Received bits land in three bytes, MSB first
// - Execute 0x02 raises select, no transfer
// - Diagnostic enable bit selects loopback mode
// - Loopback feeds transmitted bits into receive path
// - Loopback path is purely internal
// - Pins hold last levels during loopback
// - Loopback receive equals transmitted value
// - Select pin frozen at loopback entry
// - Polarity inverts clock, phase picks sample edge
// - Five-bit count gives 1 to 24 bits
// - Pin functions enabled only by pin-enable bit
// - Device drives clock, data-out, select; samples data-in
`timescale 1ns/1ps
`default_nettype none
module slc_top
  import slc_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic mosi_o,
  output logic mosi_oe_o,
  output logic ss_n_o,
  output logic ss_n_oe_o,
  input wire logic miso_i
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [4:0] cnt_q;
  logic cpha_q;
  logic cpol_q;
  logic ss_ctrl_q;
  logic go_q;
  logic [23:0] tx_q;
  logic [23:0] rx_q;
  logic loop_q;
  logic pin_en_q;
  logic done_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  slc_state_type state_q;
  logic [7:0] div_q;
  logic [5:0] edge_q;
  logic sclk_int_q;
  logic mosi_int_q;
  logic [23:0] tx_sh_q;
  logic [23:0] rx_sh_q;
  logic sclk_q;
  logic mosi_q;
  logic ss_n_q;
  logic oe_q;
  logic miso_s;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_err;
  logic [4:0] n_eff;
  logic [23:0] tx_load;
  logic lead;
  logic sample;
  logic rx_bit;
  logic [23:0] rx_nxt;
  logic last_edge;

  slc_sync2 #(
    .WIDTH(1)
  ) u_miso_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(miso_i),
    .q_o(miso_s)
  );

  // ----------------------------------------------------------------
  // APB write side
  // ----------------------------------------------------------------
  assign wr_en = psel_i & penable_i & pready_q & pwrite_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= CONFIG_RST[4:0];
      cpha_q <= CONFIG_RST[CFG_CPHA_BIT];
      cpol_q <= CONFIG_RST[CFG_CPOL_BIT];
      ss_ctrl_q <= SS_RST;
      go_q <= 1'b0;
      tx_q <= '0;
      loop_q <= 1'b0;
      pin_en_q <= 1'b0;
    end else begin
      // Trigger is a one-cycle pulse; a start while busy is dropped
      go_q <= 1'b0;
      if (wr_en) begin
        if (paddr_i == OFS_CONFIG) begin
          cnt_q <= pwdata_i[CFG_CNT_LSB+:5];
          cpha_q <= pwdata_i[CFG_CPHA_BIT];
          cpol_q <= pwdata_i[CFG_CPOL_BIT];
        end else if (paddr_i == OFS_EXECUTE) begin
          ss_ctrl_q <= pwdata_i[EXE_SS_BIT];
          go_q <= pwdata_i[EXE_GO_BIT] & (state_q == SLC_IDLE) & ~go_q;
        end else if (paddr_i == OFS_TX_LOW) begin
          tx_q[7:0] <= pwdata_i[7:0];
        end else if (paddr_i == OFS_TX_MID) begin
          tx_q[15:8] <= pwdata_i[7:0];
        end else if (paddr_i == OFS_TX_HIGH) begin
          tx_q[23:16] <= pwdata_i[7:0];
        end else if (paddr_i == OFS_DIAG) begin
          loop_q <= pwdata_i[DIAG_LOOP_BIT];
        end else if (paddr_i == OFS_PIN_CFG) begin
          pin_en_q <= pwdata_i[PIN_EN_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr_i == OFS_CONFIG) begin
      rd_data[6:0] = {cpol_q, cpha_q, cnt_q};
    end else if (paddr_i == OFS_EXECUTE) begin
      rd_data[EXE_SS_BIT] = ss_ctrl_q;
    end else if (paddr_i == OFS_TX_LOW) begin
      rd_data[7:0] = tx_q[7:0];
    end else if (paddr_i == OFS_TX_MID) begin
      rd_data[7:0] = tx_q[15:8];
    end else if (paddr_i == OFS_TX_HIGH) begin
      rd_data[7:0] = tx_q[23:16];
    end else if (paddr_i == OFS_RX_LOW) begin
      rd_data[7:0] = rx_q[7:0];
    end else if (paddr_i == OFS_RX_MID) begin
      rd_data[7:0] = rx_q[15:8];
    end else if (paddr_i == OFS_RX_HIGH) begin
      rd_data[7:0] = rx_q[23:16];
    end else if (paddr_i == OFS_DIAG) begin
      rd_data[DIAG_LOOP_BIT] = loop_q;
    end else if (paddr_i == OFS_PIN_CFG) begin
      rd_data[PIN_EN_BIT] = pin_en_q;
    end else if (paddr_i == OFS_STATUS) begin
      rd_data[STAT_BUSY_BIT] = go_q | (state_q == SLC_SHIFT);
      rd_data[STAT_DONE_BIT] = done_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // One wait state keeps every response output registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q & rd_err;
      if (psel_i & penable_i & ~pready_q & ~pwrite_i) begin
        prdata_q <= rd_data;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  // Out-of-range counts are clamped rather than rejected
  assign n_eff = (cnt_q == 5'h00) ? CNT_MIN : ((cnt_q > CNT_MAX) ? CNT_MAX : cnt_q);
  assign tx_load = tx_q << (CNT_MAX - n_eff);
  assign lead = ~edge_q[0];
  assign sample = lead ^ cpha_q;
  assign rx_bit = loop_q ? mosi_int_q : miso_s;
  assign rx_nxt = sample ? {rx_sh_q[22:0], rx_bit} : rx_sh_q;
  assign last_edge = (edge_q == ({1'b0, n_eff} << 1) - 6'h01);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SLC_IDLE;
      div_q <= 8'h00;
      edge_q <= 6'h00;
      sclk_int_q <= 1'b0;
      mosi_int_q <= 1'b0;
      tx_sh_q <= 24'h00_0000;
      rx_sh_q <= 24'h00_0000;
      rx_q <= 24'h00_0000;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        SLC_IDLE: begin
          sclk_int_q <= cpol_q;
          if (go_q) begin
            state_q <= SLC_SHIFT;
            div_q <= 8'h00;
            edge_q <= 6'h00;
            done_q <= 1'b0;
            rx_sh_q <= 24'h00_0000;
            // Phase 0 must present its first bit before the first edge
            if (!cpha_q) begin
              mosi_int_q <= tx_load[23];
              tx_sh_q <= tx_load << 1;
            end else begin
              tx_sh_q <= tx_load;
            end
          end
        end
        SLC_SHIFT: begin
          if (div_q == 8'(HALF_CYC - 1)) begin
            div_q <= 8'h00;
            sclk_int_q <= ~sclk_int_q;
            edge_q <= edge_q + 6'h01;
            rx_sh_q <= rx_nxt;
            if (!sample && !last_edge) begin
              mosi_int_q <= tx_sh_q[23];
              tx_sh_q <= tx_sh_q << 1;
            end
            if (last_edge) begin
              state_q <= SLC_IDLE;
              rx_q <= rx_nxt;
              done_q <= 1'b1;
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        default: begin
          state_q <= SLC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Pins only follow the engine outside loopback, so they keep the
  // level they had, select included, when loopback was entered.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      ss_n_q <= SS_RST;
      oe_q <= 1'b0;
    end else begin
      oe_q <= pin_en_q;
      if (!loop_q) begin
        sclk_q <= (state_q == SLC_SHIFT) ? sclk_int_q : cpol_q;
        mosi_q <= mosi_int_q;
        ss_n_q <= ss_ctrl_q;
      end
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign sclk_o = sclk_q;
  assign mosi_o = mosi_q;
  assign ss_n_o = ss_n_q;
  assign sclk_oe_o = oe_q;
  assign mosi_oe_o = oe_q;
  assign ss_n_oe_o = oe_q;
endmodule // slc_top
`default_nettype wire
